// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the timer status flags
// Assumes: CE held high except during one event pulse near the end
// Notes: Xorshift stimulus seeded at 19
`timescale 1ns/1ps
module tb_top import tsf_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  tsf_bus_type b = '0;
  tsf_ch0_evt_type ev = '0;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] rdata;
  logic wrap = 1'b0;
  logic irq;
  logic [7:0] mode = 8'h00;
  logic [7:0] cap = 8'h00;
  logic [127:0] val = '0;
  logic [127:0] tv;
  logic [31:0] s = 32'h00000013;
  logic [31:0] base;
  int n_mismatch = 0;
  int samples_checked = 0;
  tsf_status dut (.REF_CLK(clk), .RST(rst), .CE(ce), .BUS(b), .RDATA(rdata), .CH0_EVT(ev),
    .CH1_COUNT(cnt), .CH1_COUNT_WRAP(wrap), .CH1_GR_CAPTURE_MODE(mode),
    .CH1_GR_CAPTURE(cap), .CH1_GR_VALUE(val), .IRQ(irq));
  // ****************
  // Helpers
  // ****************
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [15:0] exp0(int j);
    return 16'h0001 << (j < 4 ? j : j - 1);
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    b <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    b <= '0;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    b <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    b <= '0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic pulse(tsf_ch0_evt_type e, logic [7:0] c, logic w);
    ev <= e;
    cap <= c;
    wrap <= w;
    @(posedge clk);
    ev <= '0;
    cap <= 8'h00;
    wrap <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'hf, 16'h0000);
    for (int j = 0; j < 9; j++) begin
      pulse(tsf_ch0_evt_type'(9'h001 << j), 8'h00, 1'b0);
      rd(4'h0, exp0(j));
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0000);
    end
    $display("ch0 flags done");
    for (int g = 0; g < 8; g++) begin
      base = rnd();
      for (int k = 0; k < 8; k++)
        tv[k*16 +: 16] = base[15:0] + 16'(k);
      val <= tv;
      mode <= base[23:16] | 8'h04;
      cnt <= base[15:0] - 16'h0001;
      @(posedge clk);
      if (mode[g]) begin
        pulse('0, 8'h01 << g, 1'b0);
      end else begin
        cnt <= base[15:0] + 16'(g);
        @(posedge clk);
      end
      rd(4'h1, 16'h0001 << g);
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0000);
    end
    pulse('0, 8'h00, 1'b1);
    rd(4'h1, 16'h0100);
    $display("ch1 flags done");
    pulse(tsf_ch0_evt_type'(9'h001), 8'h00, 1'b0);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0001);
    wr(4'h0, 16'h00ff);
    rd(4'h0, 16'h0001);
    b <= '{4'h0, 16'h0000, 1'b1, 1'b0};
    ev.cap_a <= 1'b1;
    @(posedge clk);
    b <= '0;
    ev <= '0;
    @(posedge clk);
    rd(4'h0, 16'h0001);
    wr(4'h2, 16'h0001);
    #1 chk({15'h0000, irq}, 16'h0001);
    @(posedge clk);
    wr(4'h2, 16'h0000);
    #1 chk({15'h0000, irq}, 16'h0000);
    @(posedge clk);
    ce <= 1'b0;
    pulse(tsf_ch0_evt_type'(9'h002), 8'h00, 1'b0);
    ce <= 1'b1;
    rd(4'h0, 16'h0001);
    $display("clear and irq done");
    end_sim();
  end
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule

// ---- bench/tsf_status_properties.sv ----
// Purpose: Port-level checks of the timer status flags
// Assumes: Flags are seen only through RDATA
// Notes: Sequences allow one idle cycle between steps
`timescale 1ns/1ps
module tsf_status_properties
  import tsf_pkg::*;
(
  // Clock, reset and enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // Register port
  input wire tsf_bus_type BUS,
  input wire logic [TSF_DW-1:0] RDATA,
  // Events
  input wire tsf_ch0_evt_type CH0_EVT,
  input wire logic CH1_COUNT_WRAP,
  input wire logic [TSF_GR_NUM-1:0] CH1_GR_CAPTURE_MODE,
  input wire logic [TSF_GR_NUM-1:0] CH1_GR_CAPTURE
);
  // ****************
  // Checks
  // ****************
  wire logic rd0 = CE && BUS.rd && BUS.addr == TSF_CH0_STATUS_OFF;
  wire logic rd1 = CE && BUS.rd && BUS.addr == TSF_CH1_STATUS_OFF;
  wire logic quiet = CE && !BUS.wr;
  wire logic ones = CE && BUS.wr && BUS.addr == TSF_CH0_STATUS_OFF && BUS.wdata == 16'h00ff;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_rsvd0_zero: assert property (rd0 |=> RDATA[15:8] == 8'h00) else $error("ch0 rsvd");
  a_rsvd1_zero: assert property (rd1 |=> RDATA[15:9] == 7'h00) else $error("ch1 rsvd");
  a_idle_zero: assert property (CE && !BUS.rd |=> RDATA == 16'h0000) else $error("idle data");
  a_capa_sets: assert property (CE && CH0_EVT.cap_a ##1 quiet ##1 rd0 |=> RDATA[0])
    else $error("cap a lost");
  a_ivb2_sets: assert property (CE && CH0_EVT.ivl_b2 ##1 quiet ##1 rd0 |=> RDATA[7])
    else $error("ivl b2 lost");
  a_wrap0_sets: assert property (CE && CH0_EVT.wrap ##1 quiet ##1 rd0 |=> RDATA[4])
    else $error("wrap0 lost");
  a_ch10_sets: assert property (CE && CH0_EVT.cap_d_ch10 ##1 quiet ##1 rd0 |=> RDATA[3])
    else $error("ch10 lost");
  a_wrap1_sets: assert property (CE && CH1_COUNT_WRAP ##1 quiet ##1 rd1 |=> RDATA[8])
    else $error("wrap1 lost");
  a_cap1_sets: assert property (CE && CH1_GR_CAPTURE[2] && CH1_GR_CAPTURE_MODE[2]
    ##1 quiet ##1 rd1 |=> RDATA[2]) else $error("gr capture lost");
  a_ones_keep: assert property (rd0 ##2 ones ##2 rd0 |=>
    (RDATA & $past(RDATA, 4)) == $past(RDATA, 4)) else $error("write one cleared");
endmodule
bind tsf_status tsf_status_properties u_props (.REF_CLK(REF_CLK), .RST(RST), .CE(CE),
  .BUS(BUS), .RDATA(RDATA), .CH0_EVT(CH0_EVT), .CH1_COUNT_WRAP(CH1_COUNT_WRAP),
  .CH1_GR_CAPTURE_MODE(CH1_GR_CAPTURE_MODE), .CH1_GR_CAPTURE(CH1_GR_CAPTURE));

// ---- hdl/tsf_status.sv ----
// Purpose: Status flags of timer channels 0 and 1 with interrupt
// Assumes: Events are one-cycle pulses synchronous to REF_CLK
// Notes: Counter and general-register values are supplied by the timer
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module tsf_status
  import tsf_pkg::*;
#(
  parameter int CH0_CNT_W = 32,
  parameter int CH1_CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // Register port
  input wire tsf_bus_type BUS,
  output logic [TSF_DW-1:0] RDATA,
  // Channel 0 events
  input wire tsf_ch0_evt_type CH0_EVT,
  // Channel 1 counter and general registers
  input wire logic [CH1_CNT_W-1:0] CH1_COUNT,
  input wire logic CH1_COUNT_WRAP,
  input wire logic [TSF_GR_NUM-1:0] CH1_GR_CAPTURE_MODE,
  input wire logic [TSF_GR_NUM-1:0] CH1_GR_CAPTURE,
  input wire logic [TSF_GR_NUM*CH1_CNT_W-1:0] CH1_GR_VALUE,
  // Interrupt
  output logic IRQ
);

  logic [TSF_CH0_FLAGS-1:0] ch0_flags_r;
  logic [TSF_CH1_FLAGS-1:0] ch1_flags_r;
  logic [TSF_CH0_FLAGS-1:0] ch0_armed_r;
  logic [TSF_CH1_FLAGS-1:0] ch1_armed_r;
  logic [TSF_CH0_FLAGS-1:0] ch0_mask_r;
  logic [TSF_CH1_FLAGS-1:0] ch1_mask_r;
  logic [TSF_CH0_FLAGS-1:0] ch0_set;
  logic [TSF_CH1_FLAGS-1:0] ch1_set;
  logic [TSF_CH0_FLAGS-1:0] ch0_clr;
  logic [TSF_CH1_FLAGS-1:0] ch1_clr;
  logic [TSF_GR_NUM-1:0] gr_hit;
  logic [TSF_DW-1:0] rdata_nxt;
  logic [CH1_CNT_W-1:0] ch1_count_d_r;
  logic wr0;
  logic wr1;
  logic rd0;
  logic rd1;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign wr0 = BUS.wr && (BUS.addr == TSF_CH0_STATUS_OFF);
  assign wr1 = BUS.wr && (BUS.addr == TSF_CH1_STATUS_OFF);
  assign rd0 = BUS.rd && (BUS.addr == TSF_CH0_STATUS_OFF);
  assign rd1 = BUS.rd && (BUS.addr == TSF_CH1_STATUS_OFF);

  // ****************************************************************
  // Set events
  // ****************************************************************
  always_comb begin
    ch0_set = '0;
    ch0_set[TSF_CH0_IVB2_BIT] = CH0_EVT.ivl_b2;
    ch0_set[TSF_CH0_IVA2_BIT] = CH0_EVT.ivl_a2;
    ch0_set[TSF_CH0_IV1_BIT] = CH0_EVT.ivl_one;
    ch0_set[TSF_CH0_WRAP_BIT] = CH0_EVT.wrap;
    ch0_set[TSF_CH0_CAPD_BIT] = CH0_EVT.cap_d | CH0_EVT.cap_d_ch10;
    ch0_set[TSF_CH0_CAPC_BIT] = CH0_EVT.cap_c;
    ch0_set[TSF_CH0_CAPB_BIT] = CH0_EVT.cap_b;
    ch0_set[TSF_CH0_CAPA_BIT] = CH0_EVT.cap_a;
  end

  // Compare fires once when the count first equals the register
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ch1_count_d_r <= '0;
    end else if (CE) begin
      ch1_count_d_r <= CH1_COUNT;
    end
  end

  generate
    for (genvar g = 0; g < TSF_GR_NUM; g++) begin : g_gr
      logic eq;
      assign eq = CH1_COUNT == CH1_GR_VALUE[g*CH1_CNT_W +: CH1_CNT_W];
      assign gr_hit[g] = CH1_GR_CAPTURE_MODE[g] ? CH1_GR_CAPTURE[g]
                       : (eq && (ch1_count_d_r != CH1_COUNT));
    end
  endgenerate

  assign ch1_set = {CH1_COUNT_WRAP, gr_hit};

  // ****************************************************************
  // Read-then-write-zero clearing
  // ****************************************************************
  // Arm records flags seen as one by a read; a later zero write clears
  assign ch0_clr = {TSF_CH0_FLAGS{wr0}} & ~BUS.wdata[TSF_CH0_FLAGS-1:0] & ch0_armed_r;
  assign ch1_clr = {TSF_CH1_FLAGS{wr1}} & ~BUS.wdata[TSF_CH1_FLAGS-1:0] & ch1_armed_r;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ch0_armed_r <= TSF_CH0_RESET;
      ch1_armed_r <= TSF_CH1_RESET;
    end else if (CE) begin
      if (rd0) begin
        ch0_armed_r <= ch0_flags_r;
      end else if (wr0) begin
        ch0_armed_r <= ch0_armed_r & ~ch0_clr;
      end
      if (rd1) begin
        ch1_armed_r <= ch1_flags_r;
      end else if (wr1) begin
        ch1_armed_r <= ch1_armed_r & ~ch1_clr;
      end
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ch0_flags_r <= TSF_CH0_RESET;
      ch1_flags_r <= TSF_CH1_RESET;
    end else if (CE) begin
      ch0_flags_r <= (ch0_flags_r & ~ch0_clr) | ch0_set;
      ch1_flags_r <= (ch1_flags_r & ~ch1_clr) | ch1_set;
    end
  end

  // ****************************************************************
  // Interrupt masks
  // ****************************************************************
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ch0_mask_r <= TSF_CH0_RESET;
      ch1_mask_r <= TSF_CH1_RESET;
    end else if (CE && BUS.wr) begin
      if (BUS.addr == TSF_CH0_MASK_OFF) begin
        ch0_mask_r <= BUS.wdata[TSF_CH0_FLAGS-1:0];
      end else if (BUS.addr == TSF_CH1_MASK_OFF) begin
        ch1_mask_r <= BUS.wdata[TSF_CH1_FLAGS-1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(((ch0_flags_r & ~ch0_clr) | ch0_set) & ch0_mask_r)
           | |(((ch1_flags_r & ~ch1_clr) | ch1_set) & ch1_mask_r);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rdata_nxt = '0;
    if (BUS.addr == TSF_CH0_STATUS_OFF) begin
      rdata_nxt = {8'h00, ch0_flags_r};
    end else if (BUS.addr == TSF_CH1_STATUS_OFF) begin
      rdata_nxt = {7'h00, ch1_flags_r};
    end else if (BUS.addr == TSF_CH0_MASK_OFF) begin
      rdata_nxt = {8'h00, ch0_mask_r};
    end else if (BUS.addr == TSF_CH1_MASK_OFF) begin
      rdata_nxt = {7'h00, ch1_mask_r};
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= TSF_RDATA_RESET;
    end else if (CE) begin
      RDATA <= BUS.rd ? rdata_nxt : TSF_RDATA_RESET;
    end
  end

endmodule

// ---- pkg/tsf_pkg.sv ----
// Purpose: Constants and types for the two-channel timer status flags
// Assumes: 16-bit register port, 100 MHz REF_CLK
// Notes: Offsets of the status and mask words are local choices
// How it works
// - Writing one to a flag keeps it
// - Clear needs prior read of one, then zero
// - Channel 0 bits 15..8 read zero
// - Channel 1 bits 15..9 read zero
// - Bit 7 sets on interval event b2
// - Bit 6 sets on interval event a2
// - Bit 5 sets on interval event one
// - Bit 4 sets on 32-bit counter wrap
// - Bit 3 sets on capture D or ch10
// - Bits 2..0 set on captures C, B, A
// - Channel 1 bit 8 sets on counter wrap
// - Channel 1 bits 7..0 are flags H..A
// - Capture mode: flag sets on capture
// - Compare mode: flag sets on match
// - Every general register sets only own flag
package tsf_pkg;

  localparam int TSF_AW = 4;
  localparam int TSF_DW = 16;
  localparam int TSF_CH0_FLAGS = 8;
  localparam int TSF_CH1_FLAGS = 9;
  localparam int TSF_GR_NUM = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [TSF_AW-1:0] TSF_CH0_STATUS_OFF = 4'h0;
  localparam logic [TSF_AW-1:0] TSF_CH1_STATUS_OFF = 4'h1;
  localparam logic [TSF_AW-1:0] TSF_CH0_MASK_OFF = 4'h2;
  localparam logic [TSF_AW-1:0] TSF_CH1_MASK_OFF = 4'h3;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int TSF_CH0_IVB2_BIT = 7;
  localparam int TSF_CH0_IVA2_BIT = 6;
  localparam int TSF_CH0_IV1_BIT = 5;
  localparam int TSF_CH0_WRAP_BIT = 4;
  localparam int TSF_CH0_CAPD_BIT = 3;
  localparam int TSF_CH0_CAPC_BIT = 2;
  localparam int TSF_CH0_CAPB_BIT = 1;
  localparam int TSF_CH0_CAPA_BIT = 0;
  localparam int TSF_CH1_WRAP_BIT = 8;
  localparam logic [TSF_CH0_FLAGS-1:0] TSF_CH0_RESET = 8'h00;
  localparam logic [TSF_CH1_FLAGS-1:0] TSF_CH1_RESET = 9'h000;
  localparam logic [TSF_DW-1:0] TSF_RDATA_RESET = 16'h0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [TSF_AW-1:0] addr;
    logic [TSF_DW-1:0] wdata;
    logic wr;
    logic rd;
  } tsf_bus_type;

  typedef struct packed {
    logic ivl_b2;
    logic ivl_a2;
    logic ivl_one;
    logic wrap;
    logic cap_d;
    logic cap_d_ch10;
    logic cap_c;
    logic cap_b;
    logic cap_a;
  } tsf_ch0_evt_type;

endpackage
